// *** rtl/mg_params.svh ***
// Offsets, bit positions, reset values and fetch figures of the memory guard.
`ifndef MG_PARAMS_SVH
`define MG_PARAMS_SVH
`define MG_REG_BASE_1     32'hFFFF_F700
`define MG_REG_BASE_2     32'hFFFF_F600
`define MG_REG_SPAN_MASK  32'hFFFF_FF00
`define MG_OFS_KEY0       8'h00
`define MG_OFS_MATCH_FIELD_1       8'h04
`define MG_OFS_MATCH_FIELD_2       8'h08
`define MG_OFS_MATCH_FIELD_3       8'h0C
`define MG_OFS_SCR        8'h24
`define MG_OFS_CODE0      32'h0000_0000
`define MG_OFS_CODE3      32'h0000_000C
`define MG_SCR_FORCE_BIT  31
`define MG_SCR_LOCK_BIT   0
`define MG_CODE_BACK_1    32'h0000_0020
`define MG_CODE_BACK_2    32'h0000_0010
`define MG_SECTOR_END_DEF 32'h0000_2000
`define MG_LOCK_RST       1'b1
`define MG_KEY_RST        32'h0000_0000
`define MG_CODE_LAST      2'h3
`endif

// *** rtl/mg_pkg.sv ***
// Types shared by the memory guard modules.
package mg_pkg;
	typedef enum logic [1:0] {
		MG_SEQ_IDLE  = 2'b00,
		MG_SEQ_READ  = 2'b01,
		MG_SEQ_WRITE = 2'b10
	} mg_seq_type;
	typedef enum logic [1:0] {
		MG_TGT_NONE = 2'b00,
		MG_TGT_KEY  = 2'b01,
		MG_TGT_SCR  = 2'b10,
		MG_TGT_CODE = 2'b11
	} mg_tgt_type;
	typedef enum logic [1:0] {
		MG_FET_REQ  = 2'b00,
		MG_FET_WAIT = 2'b01,
		MG_FET_DONE = 2'b10
	} mg_fetch_type;
endpackage

// *** rtl/mg_code_fetch.sv ***
// Loads the four unlock-code words from flash after reset or a relock.
`timescale 1ns/1ps
`default_nettype none
`include "mg_params.svh"
module mg_code_fetch
	import mg_pkg::*;
(
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Control
	input  wire logic         refetch_i,
	input  wire logic [31:0]  base_i,
	// Flash read port
	output logic              flash_rd_o,
	output logic [31:0]       flash_adr_o,
	input  wire logic [31:0]  flash_dat_i,
	input  wire logic         flash_ack_i,
	// Result
	output logic [127:0]      code_o,
	output logic              done_o
);
	mg_fetch_type state_ff;
	logic [1:0]   idx_ff;

	assign done_o = (state_ff == MG_FET_DONE);

	always_ff @(posedge clk_i)
	begin
		if (rst_i || refetch_i)
		begin
			state_ff   <= MG_FET_REQ;
			idx_ff      <= 2'h0;
			flash_rd_o  <= 1'b0;
			flash_adr_o <= 32'h0000_0000;
		end
		else
		begin
			case (state_ff)
				MG_FET_REQ:
				begin
					// The address is registered with the request, so it is steady.
					flash_adr_o <= base_i + {28'h000_0000, idx_ff, 2'b00};
					flash_rd_o  <= 1'b1;
					state_ff   <= MG_FET_WAIT;
				end
				MG_FET_WAIT:
				begin
					if (flash_ack_i)
					begin
						flash_rd_o <= 1'b0;
						idx_ff     <= idx_ff + 2'h1;
						state_ff   <= (idx_ff == `MG_CODE_LAST) ?
							MG_FET_DONE : MG_FET_REQ;
					end
				end
				MG_FET_DONE:
					flash_rd_o <= 1'b0;
				default:
					state_ff <= MG_FET_REQ;
			endcase
		end
	end

	// Word 0 is least significant, so each word lands at its own slice.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			code_o <= '0;
		else if (state_ff == MG_FET_WAIT && flash_ack_i)
			code_o[idx_ff*32 +: 32] <= flash_dat_i;
	end
endmodule
`default_nettype wire

// *** rtl/mg_guard.sv ***
// Password lock of one securable memory zone behind a Wishbone slave.
`timescale 1ns/1ps
`default_nettype none
`include "mg_params.svh"
module mg_guard
	import mg_pkg::*;
#(
	parameter int          INSTANCE   = 1,
	parameter logic [31:0] SECTOR_END = `MG_SECTOR_END_DEF
)
(
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Wishbone slave
	input  wire logic         cyc_i,
	input  wire logic         stb_i,
	input  wire logic         we_i,
	input  wire logic [31:0]  adr_i,
	input  wire logic [3:0]   sel_i,
	input  wire logic [31:0]  dat_i,
	input  wire logic         priv_i,
	output logic              ack_o,
	output logic [31:0]       dat_o,
	// Flash read port for the code fetch
	output logic              flash_rd_o,
	output logic [31:0]       flash_adr_o,
	input  wire logic [31:0]  flash_dat_i,
	input  wire logic         flash_ack_i,
	// Code-word programming forwarded to flash
	output logic              flash_wr_o,
	output logic [31:0]       flash_wr_adr_o,
	output logic [31:0]       flash_wr_dat_o,
	// Protected memory access check
	input  wire logic         acc_valid_i,
	input  wire logic         acc_debug_i,
	input  wire logic         acc_fetch_i,
	input  wire logic         acc_from_prot_i,
	output logic              acc_deny_o,
	// Zone state
	output logic              locked_o
);
	localparam logic [31:0] REG_BASE = (INSTANCE == 1) ?
		`MG_REG_BASE_1 : `MG_REG_BASE_2;
	localparam logic [31:0] CODE_BASE = SECTOR_END - ((INSTANCE == 1) ?
		`MG_CODE_BACK_1 : `MG_CODE_BACK_2);

	logic [31:0]  key_ff [0:3];
	logic         locked_ff;
	logic         ack_ff;
	logic [31:0]  dat_ff;
	mg_seq_type   seq_ff;
	logic [1:0]   cnt_ff;
	logic         eval_ff;
	logic         fwr_ff;
	logic [31:0]  fadr_ff;
	logic [31:0]  fdat_ff;
	logic         deny_ff;
	logic [127:0] code;
	logic         code_done;
	logic         flash_rd;
	logic [31:0]  flash_adr;
	logic [127:0] key_all;
	logic         req;
	logic         commit;
	logic         wr_ok;
	logic         force_wr;
	logic         code_ones;
	logic         code_zero;
	mg_tgt_type   tgt;
	logic [31:0]  nxt_dat;

	function automatic mg_tgt_type decode(input logic [31:0] a);
		if ((a & `MG_REG_SPAN_MASK) == REG_BASE && a[1:0] == 2'b00)
		begin
			if (a[7:0] <= `MG_OFS_MATCH_FIELD_3)
				return MG_TGT_KEY;
			else if (a[7:0] == `MG_OFS_SCR)
				return MG_TGT_SCR;
			else
				return MG_TGT_NONE;
		end
		else if (a >= CODE_BASE + `MG_OFS_CODE0 &&
			a <= CODE_BASE + `MG_OFS_CODE3 && a[1:0] == 2'b00)
			return MG_TGT_CODE;
		else
			return MG_TGT_NONE;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (be[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		return r;
	endfunction

	mg_code_fetch u_fetch (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.refetch_i   (force_wr),
		.base_i      (CODE_BASE),
		.flash_rd_o  (flash_rd),
		.flash_adr_o (flash_adr),
		.flash_dat_i (flash_dat_i),
		.flash_ack_i (flash_ack_i),
		.code_o      (code),
		.done_o      (code_done)
	);

	assign key_all   = {key_ff[3], key_ff[2], key_ff[1], key_ff[0]};
	assign req       = cyc_i && stb_i;
	// Requests wait until the code is known, so no read ever races the fetch.
	assign commit    = req && ack_ff;
	assign wr_ok     = commit && we_i && priv_i;
	assign tgt       = decode(adr_i);
	assign force_wr  = wr_ok && tgt == MG_TGT_SCR &&
		sel_i[3] && dat_i[`MG_SCR_FORCE_BIT];
	assign code_ones = code_done && (&code);
	assign code_zero = code_done && (code == '0);

	always_comb
	begin
		nxt_dat = 32'h0000_0000;
		case (tgt)
			MG_TGT_KEY:
				nxt_dat = key_ff[adr_i[3:2]];
			MG_TGT_SCR:
				nxt_dat[`MG_SCR_LOCK_BIT] = locked_ff;
			MG_TGT_CODE:
				nxt_dat = locked_ff ? 32'h0000_0000 :
					code[adr_i[3:2]*32 +: 32];
			default:
				nxt_dat = 32'h0000_0000;
		endcase
	end

	// Bus answer: ack one cycle after the request, dropped the cycle after.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
		end
		else
		begin
			ack_ff <= req && !ack_ff && code_done;
			if (req && !ack_ff && code_done)
				dat_ff <= nxt_dat;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i || force_wr)
		begin
			for (int i = 0; i < 4; i++)
				key_ff[i] <= `MG_KEY_RST;
		end
		else if (wr_ok && tgt == MG_TGT_KEY)
			key_ff[adr_i[3:2]] <= merge(key_ff[adr_i[3:2]], dat_i, sel_i);
	end

	// Unlock sequence: four code reads, then four match writes.
	always_ff @(posedge clk_i)
	begin
		if (rst_i || force_wr)
		begin
			seq_ff  <= MG_SEQ_IDLE;
			cnt_ff  <= 2'h0;
			eval_ff <= 1'b0;
		end
		else
		begin
			eval_ff <= 1'b0;
			case (seq_ff)
				MG_SEQ_IDLE, MG_SEQ_READ:
				begin
					if (commit && !we_i && tgt == MG_TGT_CODE)
					begin
						cnt_ff <= cnt_ff + 2'h1;
						seq_ff <= MG_SEQ_READ;
						if (cnt_ff == `MG_CODE_LAST)
							seq_ff <= (code_ones || code_zero) ?
								MG_SEQ_IDLE : MG_SEQ_WRITE;
					end
				end
				MG_SEQ_WRITE:
				begin
					if (wr_ok && tgt == MG_TGT_KEY)
					begin
						cnt_ff <= cnt_ff + 2'h1;
						if (cnt_ff == `MG_CODE_LAST)
						begin
							eval_ff <= 1'b1;
							seq_ff  <= MG_SEQ_IDLE;
						end
					end
				end
				default:
					seq_ff <= MG_SEQ_IDLE;
			endcase
		end
	end

	// A relock shares the edge with no unlock because force_wr is tested before both unlock terms.
	always_ff @(posedge clk_i)
	begin
		if (rst_i || force_wr)
			locked_ff <= `MG_LOCK_RST;
		else if (code_zero)
			locked_ff <= 1'b1;
		else if (seq_ff != MG_SEQ_WRITE && commit && !we_i &&
			tgt == MG_TGT_CODE && cnt_ff == `MG_CODE_LAST && code_ones)
			locked_ff <= 1'b0;
		else if (eval_ff && key_all == code)
			locked_ff <= 1'b0;
	end

	// Code words live in flash, so programming them obeys the zone lock.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fwr_ff  <= 1'b0;
			fadr_ff <= 32'h0000_0000;
			fdat_ff <= 32'h0000_0000;
		end
		else
		begin
			fwr_ff <= wr_ok && tgt == MG_TGT_CODE && !locked_ff;
			if (wr_ok && tgt == MG_TGT_CODE)
			begin
				fadr_ff <= adr_i;
				fdat_ff <= dat_i;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			deny_ff <= 1'b0;
		else
			deny_ff <= acc_valid_i && locked_ff && !acc_fetch_i &&
				(acc_debug_i || !acc_from_prot_i);
	end

	assign ack_o          = ack_ff;
	assign dat_o          = dat_ff;
	assign flash_rd_o     = flash_rd;
	assign flash_adr_o    = flash_adr;
	assign flash_wr_o     = fwr_ff;
	assign flash_wr_adr_o = fadr_ff;
	assign flash_wr_dat_o = fdat_ff;
	assign acc_deny_o     = deny_ff;
	assign locked_o       = locked_ff;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Privileged force-lock write with the top byte lane enabled.
	sequence s_force;
		commit && we_i && priv_i && tgt == MG_TGT_SCR && sel_i[3] &&
			dat_i[`MG_SCR_FORCE_BIT];
	endsequence

	// Fourth counted code read; an all-ones code unlocks on its edge.
	sequence s_last_code_read;
		commit && !we_i && tgt == MG_TGT_CODE && seq_ff != MG_SEQ_WRITE &&
			cnt_ff == `MG_CODE_LAST;
	endsequence

	// Fourth privileged match write, then a full match when it is judged.
	sequence s_full_match;
		wr_ok && tgt == MG_TGT_KEY && seq_ff == MG_SEQ_WRITE &&
			cnt_ff == `MG_CODE_LAST ##1 key_all == code;
	endsequence

	// All checks sleep through reset, since the fetch restarts there.
	a_force_relock: assert property (s_force |=>
		locked_ff && key_all == '0)
		else $error("Force write did not relock and clear.");
	a_reset_lock: assert property ($past(rst_i) |-> locked_ff)
		else $error("Zone not locked after reset.");
	a_scr_read: assert property (ack_ff && !we_i &&
		tgt == MG_TGT_SCR |-> dat_ff[`MG_SCR_FORCE_BIT] == 1'b0 &&
		dat_ff[`MG_SCR_LOCK_BIT] == $past(locked_ff))
		else $error("Status read shows wrong bits.");
	a_code_hidden: assert property (ack_ff && !we_i &&
		tgt == MG_TGT_CODE && $past(locked_ff) |-> dat_ff == 32'h0000_0000)
		else $error("Code exposed while locked.");
	a_unpriv_key: assert property (commit && we_i && !priv_i |=>
		$stable(key_all) && $stable(locked_ff))
		else $error("Unprivileged write changed state.");
	a_zero_code: assert property (code_zero |=> locked_ff)
		else $error("All-zero code let the zone unlock.");
	a_mismatch: assert property (eval_ff && key_all != code &&
		locked_ff |=> locked_ff)
		else $error("Mismatch changed the lock.");
	a_eval_after_write: assert property (eval_ff |->
		$past(wr_ok && tgt == MG_TGT_KEY && seq_ff == MG_SEQ_WRITE))
		else $error("Match judged without a fourth match write.");
	a_deny_debug: assert property (acc_valid_i && acc_debug_i &&
		!acc_fetch_i && locked_ff |=> acc_deny_o)
		else $error("Locked debug access not denied.");
	a_flash_guard: assert property (fwr_ff |-> !$past(locked_ff))
		else $error("Code write forwarded while locked.");
	a_ones_unlock: assert property (
		s_last_code_read ##0 code_ones |=> !locked_ff)
		else $error("All-ones code did not unlock after the reads.");
	a_match_unlock: assert property (s_full_match |=> !locked_ff)
		else $error("Full match after four writes did not unlock.");
	a_ack_waits_fetch: assert property (!code_done |=> !ack_ff)
		else $error("Bus answered before the code was fetched.");
	a_ack_pulse: assert property (ack_ff |=> !ack_ff)
		else $error("Ack held longer than one cycle.");
endmodule
`default_nettype wire

// *** verif/mg_flash_model.sv ***
// Flash read port model that serves one zone's four unlock-code words.
`timescale 1ns/1ps
`default_nettype none
module mg_flash_model
#(
	parameter logic [31:0] CODE_BASE = 32'h0000_1FE0,
	parameter int          DELAY     = 0
)
(
	// Clock
	input  wire logic         clk_i,
	// Code contents
	input  wire logic [127:0] code_i,
	// Read port
	input  wire logic         rd_i,
	input  wire logic [31:0]  adr_i,
	output logic [31:0]       dat_o,
	output logic              ack_o
);
	int          wait_cnt = 0;
	logic        hit;
	logic [31:0] dat_q = 32'h0000_0000;
	logic        ack_q = 1'b0;
	assign hit = adr_i[31:4] == CODE_BASE[31:4] && adr_i[1:0] == 2'h0;
	assign dat_o = dat_q;
	assign ack_o = ack_q;
	// Idle data toggles every cycle, so a stale word is never taken as valid.
	always @(posedge clk_i)
	begin
		ack_q <= 1'b0;
		dat_q <= ~dat_q;
		wait_cnt <= rd_i ? wait_cnt + 1 : 0;
		if (rd_i && !ack_q && wait_cnt >= DELAY)
		begin
			ack_q <= 1'b1;
			wait_cnt <= 0;
			// A wrong fetch address yields a corrupt word, so unlock then fails.
			dat_q <= hit ? code_i[{adr_i[3:2], 5'h00} +: 32] :
				~code_i[31:0];
		end
	end
endmodule
`default_nettype wire

// *** verif/memory_password_lock_tb_top.sv ***
// Self-checking bench for both memory guard zones on one Wishbone bus.
`timescale 1ns/1ps
`default_nettype none
module memory_password_lock_tb_top
	import mg_pkg::*;
;
	localparam logic [31:0] SCR = 32'hFFFF_F724;
	localparam logic [31:0] FRC = 32'h8000_0000;
	logic         clk_i = 1'b0;
	logic         rst_i = 1'b1;
	logic         cyc = 1'b0;
	logic         we = 1'b0;
	logic         priv = 1'b0;
	logic [1:0]   stb = 2'b00;
	logic [3:0]   sel = 4'hF;
	logic [31:0]  adr = 32'h0000_0000;
	logic [31:0]  wdat = 32'h0000_0000;
	logic [3:0]   accs = 4'h0;
	logic         wseen = 1'b0;
	logic [31:0]  wadr_seen = 32'h0000_0000;
	logic [31:0]  wdat_seen = 32'h0000_0000;
	logic [127:0] code [2];
	logic         ack [2], frd [2], fack [2], fwr [2], lock [2], deny [2];
	logic [31:0]  rdat [2], fadr [2], fdat [2];
	logic [31:0]  fwa [2], fwd [2];
	logic [31:0]  q;
	int           checked = 0;
	int           miscompares = 0;
	int           cycles = 0;
	always #10 clk_i = ~clk_i;
	for (genvar g = 0; g < 2; g++)
	begin : g_zone
		mg_guard #(.INSTANCE(g + 1)) mg_guard_inst (.clk_i(clk_i),
			.rst_i(rst_i), .cyc_i(cyc), .stb_i(stb[g]), .we_i(we),
			.adr_i(adr), .sel_i(sel), .dat_i(wdat), .priv_i(priv),
			.ack_o(ack[g]), .dat_o(rdat[g]), .flash_rd_o(frd[g]),
			.flash_adr_o(fadr[g]), .flash_dat_i(fdat[g]),
			.flash_ack_i(fack[g]), .flash_wr_o(fwr[g]),
			.flash_wr_adr_o(fwa[g]), .flash_wr_dat_o(fwd[g]),
			.acc_valid_i(accs[3]),
			.acc_debug_i(accs[2]), .acc_fetch_i(accs[1]),
			.acc_from_prot_i(accs[0]), .acc_deny_o(deny[g]),
			.locked_o(lock[g]));
		mg_flash_model #(.CODE_BASE(g ? 32'h0000_1FF0 : 32'h0000_1FE0),
			.DELAY(3 * g)) mg_flash_model_inst (.clk_i(clk_i),
			.code_i(code[g]), .rd_i(frd[g]), .adr_i(fadr[g]),
			.dat_o(fdat[g]), .ack_o(fack[g]));
	end
	// Keep the last forwarded code write of zone one for later checks.
	always @(posedge clk_i)
		if (fwr[0])
		begin
			wseen     <= 1'b1;
			wadr_seen <= fwa[0];
			wdat_seen <= fwd[0];
		end
	function automatic logic [31:0] rbase(input int z);
		return z ? 32'hFFFF_F600 : 32'hFFFF_F700;
	endfunction
	function automatic logic [31:0] cbase(input int z);
		return z ? 32'h0000_1FF0 : 32'h0000_1FE0;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input int z, input logic w, input logic [31:0] a,
		input logic [31:0] d, input logic p);
		cyc <= 1'b1;
		stb <= z ? 2'b10 : 2'b01;
		we <= w;
		adr <= a;
		wdat <= d;
		priv <= p;
		@(posedge clk_i);
		while (ack[z] !== 1'b1)
			@(posedge clk_i);
		q = rdat[z];
		cyc <= 1'b0;
		stb <= 2'b00;
		@(posedge clk_i);
	endtask
	task automatic wr(input int z, input logic [31:0] a,
		input logic [31:0] d);
		bus(z, 1'b1, a, d, 1'b1);
	endtask
	task automatic rd(input int z, input logic [31:0] a,
		input logic [31:0] e);
		bus(z, 1'b0, a, '0, 1'b1);
		chk(q, e);
	endtask
	task automatic st(input int z, input logic lk);
		rd(z, rbase(z) + 32'h0000_0024, {31'h0000_0000, lk});
		chk({31'h0000_0000, lock[z]}, {31'h0000_0000, lk});
	endtask
	task automatic unlock_match_sequence(input int z, input logic [127:0] k, input logic p,
		input int nw);
		for (int i = 0; i < 4; i++)
			bus(z, 1'b0, cbase(z) + 32'(4 * i), '0, 1'b1);
		for (int i = 0; i < nw; i++)
			bus(z, 1'b1, rbase(z) + 32'(4 * i), k[32 * i +: 32], p);
		repeat (2) @(posedge clk_i);
	endtask
	task automatic acc(input int z, input logic lk);
		for (int i = 0; i < 16; i++)
		begin
			accs <= 4'(i);
			repeat (2) @(posedge clk_i);
			chk({31'h0000_0000, deny[z]},
				{31'h0000_0000, i[3] & lk & ~i[1] & (i[2] | ~i[0])});
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Whole run needs well under a thousand cycles; the ceiling leaves wide margin.
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			end_of_test();
		end
	end
	initial
	begin
		code[0] = 128'hD3C2_B1A0_9786_7564_5342_3120_0F1E_2D3C;
		code[1] = 128'h1357_9BDF_2468_ACE0_F0E1_D2C3_B4A5_9687;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		st(0, 1'b1);
		rd(0, 32'h0000_1FE0, '0);
		rd(0, 32'hFFFF_F710, '0);
		wr(0, 32'h0000_1FE4, 32'h0000_5A5A);
		@(posedge clk_i);
		chk({31'h0000_0000, wseen}, '0);
		acc(0, 1'b1);
		$display("test reset done");
		unlock_match_sequence(0, code[0], 1'b0, 4);
		st(0, 1'b1);
		wr(0, SCR, FRC);
		unlock_match_sequence(0, code[0] ^ {1'b1, 127'h0}, 1'b1, 4);
		st(0, 1'b1);
		wr(0, SCR, FRC);
		unlock_match_sequence(0, code[0], 1'b1, 4);
		st(0, 1'b0);
		for (int i = 0; i < 4; i++)
		begin
			rd(0, 32'h0000_1FE0 + 32'(4 * i), code[0][32 * i +: 32]);
			rd(0, 32'hFFFF_F700 + 32'(4 * i), code[0][32 * i +: 32]);
		end
		wr(0, 32'h0000_1FE4, 32'h0000_5A5A);
		@(posedge clk_i);
		chk({31'h0000_0000, wseen}, 32'h0000_0001);
		chk(wadr_seen, 32'h0000_1FE4);
		chk(wdat_seen, 32'h0000_5A5A);
		acc(0, 1'b0);
		wr(0, SCR, 32'h7FFF_FFFE);
		rd(0, SCR, '0);
		bus(0, 1'b1, SCR, FRC, 1'b0);
		st(0, 1'b0);
		wr(0, SCR, FRC);
		st(0, 1'b1);
		for (int i = 0; i < 4; i++)
			rd(0, 32'hFFFF_F700 + 32'(4 * i), '0);
		$display("test unlock done");
		code[0] = '1;
		wr(0, SCR, FRC);
		unlock_match_sequence(0, '0, 1'b1, 0);
		st(0, 1'b0);
		code[0] = '0;
		wr(0, SCR, FRC);
		unlock_match_sequence(0, '0, 1'b1, 4);
		st(0, 1'b1);
		$display("test special codes done");
		st(1, 1'b1);
		acc(1, 1'b1);
		unlock_match_sequence(1, code[1], 1'b1, 4);
		st(1, 1'b0);
		rd(1, 32'h0000_1FFC, code[1][127:96]);
		$display("test second zone done");
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		st(1, 1'b1);
		$display("test mid-run reset done");
		end_of_test();
	end
endmodule
`default_nettype wire
